/* hw/rcl_top.sv */
`timescale 1ns/1ps
`include "rcl_map.svh"

module rcl_top #(
   parameter int LOSS_CYCLES = `RCL_LOSS_TIME_US * `RCL_CLK_MHZ
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input rcl_pkg::rcl_analog_t analog_in,
   input rcl_pkg::rcl_pins_t pins_in,
   output rcl_pkg::rcl_diff_t primary_serial_output,
   output rcl_pkg::rcl_diff_t secondary_serial_output,
   output logic lock_indicator,
   output logic standard_rate_flag,
   input wire logic [`RCL_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import rcl_pkg::*;

   // ----------------------------------------------------------------------
   // Elaboration checks.
   // ----------------------------------------------------------------------
   // The idle counter is a fixed-width field of the state struct.
   if (LOSS_CYCLES < 1 || LOSS_CYCLES >= (1 << `RCL_IDLE_W)) begin : g_bad_loss
      $error("LOSS_CYCLES out of range for the idle counter.");
   end

   localparam logic [`RCL_IDLE_W-1:0] LOSS_LIMIT = `RCL_IDLE_W'(LOSS_CYCLES - 1);

   // ----------------------------------------------------------------------
   // Reset release.
   // ----------------------------------------------------------------------
   logic rst_s1_q;
   logic rst_s2_q;

   // Asynchronous assertion, synchronous release through two stages.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // ----------------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------------
   rcl_state_t st_q;
   rcl_state_t st_d;

   // Muted pair: true side low, complement high, never toggling.
   function automatic rcl_diff_t drive_pair(input logic bit_val, input logic muted);
      rcl_diff_t r;
      r.p = muted ? 1'b0 : bit_val;
      r.n = muted ? 1'b1 : ~bit_val;
      return r;
   endfunction : drive_pair

   // Byte-lane merge for writes to software registers.
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   // ----------------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------------
   logic force_byp;
   logic retime_ok;
   logic sec_bit;
   logic sec_mute;
   logic [31:0] status_w;
   logic [31:0] ctrl_w;
   logic [31:0] rd_val;
   logic [31:0] ctrl_new;

   always_comb begin
      st_d = st_q;
      // Only the second stage is read by the logic below.
      st_d.lock_s1 = analog_in.pll_locked;
      st_d.lock_s2 = st_q.lock_s1;
      st_d.rate_s1 = analog_in.rate_ok;
      st_d.rate_s2 = st_q.rate_s1;

      // Activity watchdog: no transition for the loss time drops presence.
      st_d.video_prev = analog_in.video_in;
      if (analog_in.video_in != st_q.video_prev) begin
         st_d.idle_cnt = '0;
         st_d.present = 1'b1;
      end else if (st_q.idle_cnt >= LOSS_LIMIT) begin
         st_d.present = 1'b0;
      end else begin
         st_d.idle_cnt = st_q.idle_cnt + `RCL_IDLE_W'(1);
      end

      // Pin pads carry pull-up on silence, pull-down on bypass and select.
      force_byp = pins_in.bypass_force | st_q.ctrl[`RCL_CTRL_BYPASS];
      st_d.lock_ind = st_q.present & st_q.lock_s2 & ~force_byp;

      // Rate flag follows the lock indicator one clock later, low when unlocked.
      st_d.rate_flag = st_q.lock_ind & st_q.lock_s2 & st_q.rate_s2;

      // Retime only when locked at a supported rate and not forced.
      retime_ok = st_d.lock_ind & st_q.rate_s2;
      st_d.bypass = ~retime_ok | force_byp;

      // Mute is decided apart from the path so a path switch cannot pulse it.
      st_d.mute = ~pins_in.output_silence_n | st_q.ctrl[`RCL_CTRL_MUTE];
      st_d.clk_sel = pins_in.second_output_clock_select | st_q.ctrl[`RCL_CTRL_CLKSEL];

      // Data paths, registered together with the mute decision.
      st_d.prim = drive_pair(st_d.bypass ? analog_in.video_in : analog_in.retimed_data,
                             st_d.mute);
      // The recovered clock is already centred by the analog sampler.
      sec_bit = st_d.clk_sel ? analog_in.recovered_clk :
                (st_d.bypass ? analog_in.video_in : analog_in.retimed_data);
      sec_mute = st_d.mute | (st_d.clk_sel & st_d.bypass);
      st_d.sec = drive_pair(sec_bit, sec_mute);

      // Lock loss counter; a loss in the clearing cycle wins and the clear is lost.
      status_w = '0;
      status_w[`RCL_ST_LOCK] = st_q.lock_ind;
      status_w[`RCL_ST_RATE] = st_q.rate_flag;
      status_w[`RCL_ST_BYPASS] = st_q.bypass;
      status_w[`RCL_ST_MUTE] = st_q.mute;
      status_w[`RCL_ST_PLL] = st_q.lock_s2;
      status_w[`RCL_ST_RATEOK] = st_q.rate_s2;
      status_w[`RCL_ST_PRESENT] = st_q.present;
      status_w[`RCL_ST_CLKSEL] = st_q.clk_sel;
      ctrl_w = {29'h0000000, st_q.ctrl};
      // Merged first, then cut, since a call result cannot be part-selected.
      ctrl_new = lane_merge(ctrl_w, avs_writedata, avs_byteenable);

      // Avalon slave: one wait cycle, then answer with waitrequest low.
      st_d.ack = (avs_read | avs_write) & ~st_q.ack;
      case (avs_address)
         `RCL_OFS_CTRL: rd_val = ctrl_w;
         `RCL_OFS_STATUS: rd_val = status_w;
         `RCL_OFS_LOSS: rd_val = {16'h0000, st_q.loss_cnt};
         default: rd_val = 32'h00000000;
      endcase
      if (avs_read & ~st_q.ack) begin
         st_d.rdata = rd_val;
      end
      if (avs_write & st_q.ack) begin
         case (avs_address)
            `RCL_OFS_CTRL: st_d.ctrl = ctrl_new[`RCL_CTRL_W-1:0];
            `RCL_OFS_LOSS: st_d.loss_cnt = '0;
            default: st_d.ctrl = st_q.ctrl;
         endcase
      end
      if (st_q.lock_ind & ~st_d.lock_ind) begin
         st_d.loss_cnt = st_q.loss_cnt + `RCL_LOSS_W'(1);
      end
   end

   // ----------------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------------
   // Reset values mute both pairs so nothing toggles before release.
   always_ff @(posedge clk_sys or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         st_q <= '0;
         st_q.mute <= 1'b1;
         st_q.bypass <= 1'b1;
         st_q.prim <= 2'h1;
         st_q.sec <= 2'h1;
         st_q.ctrl <= `RCL_CTRL_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------------
   assign primary_serial_output = st_q.prim;
   assign secondary_serial_output = st_q.sec;
   assign lock_indicator = st_q.lock_ind;
   assign standard_rate_flag = st_q.rate_flag;
   assign avs_readdata = st_q.rdata;
   assign avs_waitrequest = (avs_read | avs_write) & ~st_q.ack;

endmodule : rcl_top

/* pkg/rcl_map.svh */
//
// Contract
// - Lock indicator high when data present and locked.
// - Forced bypass holds lock indicator low.
// - Silence input low mutes both outputs.
// - Muting overrides bypass and lock state.
// - Floating silence input reads high, outputs enabled.
// - Forced bypass passes input data without retiming.
// - Auto mode bypasses when unlocked or rate unsupported.
// - Floating bypass input reads low, auto mode.
// - Lock low, unmuted: data passes unretimed.
// - Lock high, unmuted, auto: retimed data out; the code bypasses instead when the rate is unsupported.
// - Standard-rate flag high means locked at 270 Mbps.
// - Standard-rate flag registered, valid only while locked.
// - Standard-rate flag forced low while unlocked.
// - Standard-rate flag settles one period after lock.
// - Lock drops within 1 ms of input loss.
// - Clock select picks clock or data copy.
// - Floating clock select reads low, data copy.
// - Both serial outputs always driven unless muted.
// - Muted differential output holds opposite static levels.
// - Secondary clock output also muted during bypass.
// - Clock rising edge near data bit centre.
`ifndef RCL_MAP_SVH
`define RCL_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one word each).
// ----------------------------------------------------------------------
`define RCL_ADDR_W 4
`define RCL_OFS_CTRL 4'h0
`define RCL_OFS_STATUS 4'h4
`define RCL_OFS_LOSS 4'h8

// ----------------------------------------------------------------------
// Control register fields and reset value.
// ----------------------------------------------------------------------
`define RCL_CTRL_W 3
`define RCL_CTRL_MUTE 0
`define RCL_CTRL_BYPASS 1
`define RCL_CTRL_CLKSEL 2
`define RCL_CTRL_RST 3'h0

// ----------------------------------------------------------------------
// Status register fields.
// ----------------------------------------------------------------------
`define RCL_ST_LOCK 0
`define RCL_ST_RATE 1
`define RCL_ST_BYPASS 2
`define RCL_ST_MUTE 3
`define RCL_ST_PLL 4
`define RCL_ST_RATEOK 5
`define RCL_ST_PRESENT 6
`define RCL_ST_CLKSEL 7

// ----------------------------------------------------------------------
// Counters and timing.
// ----------------------------------------------------------------------
`define RCL_LOSS_W 16
`define RCL_IDLE_W 20
`define RCL_LOSS_TIME_US 1000
`define RCL_CLK_MHZ 40

`endif

/* pkg/rcl_pkg.sv */
package rcl_pkg;

   // Differential output pair.
   typedef struct packed {
      logic p;
      logic n;
   } rcl_diff_t;

   // Signals from the analog recovery circuit and the serial input.
   typedef struct packed {
      logic pll_locked;
      logic rate_ok;
      logic video_in;
      logic retimed_data;
      logic recovered_clk;
   } rcl_analog_t;

   // Board-level control pins.
   typedef struct packed {
      logic output_silence_n;
      logic bypass_force;
      logic second_output_clock_select;
   } rcl_pins_t;

   // State of the control block, all but the two reset-release stages.
   typedef struct packed {
      logic lock_s1;
      logic lock_s2;
      logic rate_s1;
      logic rate_s2;
      logic video_prev;
      logic [19:0] idle_cnt;
      logic present;
      logic lock_ind;
      logic rate_flag;
      logic bypass;
      logic mute;
      logic clk_sel;
      rcl_diff_t prim;
      rcl_diff_t sec;
      logic [2:0] ctrl;
      logic [15:0] loss_cnt;
      logic ack;
      logic [31:0] rdata;
   } rcl_state_t;

endpackage : rcl_pkg

/* verif/rcl_front_model.sv */
`timescale 1ns/1ps
// ----
// Equalizer and recovery front end.
// ----
module rcl_front_model (
   input wire logic clk_sys,
   input wire logic sig_on,
   input wire logic pll_on,
   input wire logic rate_on,
   input wire logic data_bit,
   output rcl_pkg::rcl_analog_t analog_out
);
   import rcl_pkg::*;
   logic [1:0] acq_q = 2'h0;
   logic ret_q = 1'b0;
   logic clk_q = 1'b0;
   logic vid;
   // A lost signal parks the line, so the activity timer sees no edges.
   assign vid = sig_on ? data_bit : 1'b1;
   // The PLL takes three edges to acquire, then coasts without data.
   always @(posedge clk_sys) begin
      acq_q <= !pll_on ? 2'h0 : acq_q + 2'(acq_q != 2'h3);
      ret_q <= vid;
      clk_q <= !clk_q;
   end
   assign analog_out = '{acq_q == 2'h3, rate_on, vid, ret_q, clk_q};
endmodule : rcl_front_model

/* verif/rcl_top_asserts.sv */
`timescale 1ns/1ps
// ----
// Port checks.
// ----
module rcl_chk (
   input wire logic clk_sys,
   input wire logic rstn,
   input rcl_pkg::rcl_analog_t analog_in,
   input rcl_pkg::rcl_pins_t pins_in,
   input rcl_pkg::rcl_diff_t primary_serial_output,
   input rcl_pkg::rcl_diff_t secondary_serial_output,
   input wire logic lock_indicator,
   input wire logic standard_rate_flag,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest
);
   import rcl_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // A fresh request is held off exactly one cycle.
   sequence s_new_req;
      $rose(avs_read || avs_write);
   endsequence
   sequence s_one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   chk_one_wait: assert property (s_new_req |-> s_one_wait)
      else $error("Wait not one cycle.");
   // Forced bypass holds lock low; lock follows the PLL only through the synchroniser, never faster.
   chk_force_unlock: assert property (pins_in.bypass_force |=> !lock_indicator)
      else $error("Lock during bypass.");
   chk_lock_pll: assert property (!analog_in.pll_locked [*4] |-> !lock_indicator)
      else $error("Lock without PLL.");
   chk_lock_sync: assert property ($rose(analog_in.pll_locked) |=> !lock_indicator [*2])
      else $error("PLL not synchronised.");
   // Mute wins over everything, whatever the bypass pin says.
   chk_mute_both: assert property (!pins_in.output_silence_n [*3] |->
      primary_serial_output == 2'h1 && secondary_serial_output == 2'h1)
      else $error("Output not muted.");
   // The rate flag trails the lock indicator by one edge.
   chk_flag_low: assert property (!lock_indicator |=> !standard_rate_flag)
      else $error("Flag while unlocked.");
   chk_flag_rise: assert property ((analog_in.rate_ok && analog_in.pll_locked) [*4]
      ##0 $rose(lock_indicator) |=> standard_rate_flag)
      else $error("Flag late.");
   // Bypass mutes the clock output and passes raw data on the primary.
   chk_clk_bypass: assert property ((pins_in.second_output_clock_select
      && pins_in.bypass_force) [*3] |-> secondary_serial_output == 2'h1)
      else $error("Clock not muted.");
   chk_bypass_path: assert property ((pins_in.bypass_force && pins_in.output_silence_n)
      [*3] |-> primary_serial_output.p == $past(analog_in.video_in))
      else $error("Bypass data wrong.");
endmodule : rcl_chk

bind rcl_top rcl_chk chk_u (.clk_sys, .rstn, .analog_in, .pins_in, .primary_serial_output,
   .secondary_serial_output, .lock_indicator, .standard_rate_flag, .avs_read, .avs_write,
   .avs_waitrequest);

/* verif/rcl_top_test.sv */
`timescale 1ns/1ps
`include "rcl_map.svh"
// ----
// Control block bench.
// ----
module rcl_top_test;
   import rcl_pkg::*;
   localparam int LOSS = 20;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic sig_on = 1'b0;
   logic pll_on = 1'b0;
   logic rate_on = 1'b0;
   logic data_bit = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic wt, lk, sf, vid_s, ret_s, ck_s;
   rcl_pins_t pins = 3'h4;
   rcl_analog_t an;
   rcl_diff_t po, so;
   int mismatches = 0;
   int n_compared = 0;
   rcl_front_model fm_u (.clk_sys, .sig_on, .pll_on, .rate_on, .data_bit, .analog_out(an));
   rcl_top #(.LOSS_CYCLES(LOSS)) dut_u (.clk_sys, .rstn, .analog_in(an), .pins_in(pins),
      .primary_serial_output(po), .secondary_serial_output(so), .lock_indicator(lk),
      .standard_rate_flag(sf), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wt));
   // Free-running 40 MHz clock stands in for the board reference.
   always #12.5 clk_sys = !clk_sys;
   // Random data each edge; what the block sampled is kept for the compares.
   always @(posedge clk_sys) begin
      data_bit <= 1'($urandom);
      vid_s <= an.video_in;
      ret_s <= an.retimed_data;
      ck_s <= an.recovered_clk;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check
   function automatic logic [1:0] out_exp(input logic mute, input logic d);
      return mute ? 2'h1 : {d, !d};
   endfunction : out_exp
   // Let the synchronisers settle, then compare eight bits on both pairs.
   task automatic look(input logic mute, input logic byp, input logic cm);
      logic [1:0] p;
      repeat (5) @(posedge clk_sys);
      repeat (8) begin
         @(negedge clk_sys);
         p = out_exp(mute, byp ? vid_s : ret_s);
         check("primary", 32'(po), 32'(p));
         check("secondary", 32'(so), 32'(cm ? out_exp(mute | byp, ck_s) : p));
      end
   endtask : look
   // One bus access; the request stands until waitrequest is seen low.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int t;
      t = 0;
      @(posedge clk_sys);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk_sys);
         t++;
      end while (wt !== 1'b0 && t < 50);
      if (t >= 50) begin
         mismatches++;
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic give_verdict;
      $display("compared %0d, mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict
   // Watchdog, far beyond the few hundred cycles the tests need.
   initial begin
      #100000;
      mismatches++;
      give_verdict();
   end
   // Main sequence.
   initial begin
      logic [31:0] q;
      int t;
      q = $urandom(32'h3ECE);
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      bus(1'b0, `RCL_OFS_CTRL, 32'h0, q);
      check("ctrl reset", q, 32'h0);
      bus(1'b1, `RCL_OFS_CTRL, 32'h4, q);
      bus(1'b0, `RCL_OFS_CTRL, 32'h0, q);
      check("ctrl back", q, 32'h4);
      bus(1'b1, `RCL_OFS_CTRL, 32'h0, q);
      bus(1'b0, 4'hC, 32'h0, q);
      check("unmapped", q, 32'h0);
      $display("registers done");
      sig_on <= 1'b1;
      pll_on <= 1'b1;
      rate_on <= 1'b1;
      t = 0;
      while (lk !== 1'b1 && t < 40) begin
         @(negedge clk_sys);
         t++;
      end
      check("lock up", 32'(lk), 32'h1);
      @(negedge clk_sys);
      check("rate flag", 32'(sf), 32'h1);
      look(1'b0, 1'b0, 1'b0);
      @(posedge clk_sys);
      pins <= '{1'b1, 1'b0, 1'b1};
      look(1'b0, 1'b0, 1'b1);
      @(posedge clk_sys);
      pins <= '{1'b1, 1'b1, 1'b1};
      look(1'b0, 1'b1, 1'b1);
      check("lock forced", 32'(lk), 32'h0);
      check("flag forced", 32'(sf), 32'h0);
      @(posedge clk_sys);
      pins <= '{1'b1, 1'b0, 1'b0};
      rate_on <= 1'b0;
      look(1'b0, 1'b1, 1'b0);
      check("flag no rate", 32'(sf), 32'h0);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         pins <= '{1'b0, 1'(i), 1'b1};
         look(1'b1, 1'b0, 1'b1);
      end
      @(posedge clk_sys);
      pins <= '{1'b1, 1'b0, 1'b0};
      rate_on <= 1'b1;
      look(1'b0, 1'b0, 1'b0);
      @(posedge clk_sys);
      sig_on <= 1'b0;
      t = 0;
      while (lk !== 1'b0 && t < 100) begin
         @(negedge clk_sys);
         t++;
      end
      check("loss time", 32'(t >= LOSS && t <= LOSS + 4), 32'h1);
      look(1'b0, 1'b1, 1'b0);
      // Silence tied to the low lock indicator mutes both pairs.
      @(posedge clk_sys);
      pins <= '{lk, 1'b0, 1'b0};
      look(1'b1, 1'b1, 1'b0);
      @(posedge clk_sys);
      pins <= '{1'b1, 1'b0, 1'b0};
      bus(1'b0, `RCL_OFS_LOSS, 32'h0, q);
      check("loss count", q, 32'h3);
      bus(1'b1, `RCL_OFS_LOSS, 32'h0, q);
      bus(1'b0, `RCL_OFS_LOSS, 32'h0, q);
      check("loss clear", q, 32'h0);
      $display("paths done");
      give_verdict();
   end
endmodule : rcl_top_test
